// ===== core/temp_sensor_ctrl.sv
// Conversion scheduler, data formatting, over-temperature flag and
// packet check byte engine of a digital temperature sensor.
// Assumes the bus framing logic hands over decoded register accesses
// and check-byte traffic on this clock, and that the analog front end
// delivers a sample in sixteenths of a degree on the same clock.
//
// Notes on behaviour
// - Format bit clear: normal two's complement
// - Format bit set: extended, top bit 256 deg
// - Format change applies at next completed conversion
// - Thresholds stored as written, never reformatted
// - Rate field picks 0.25, 1, 4, 8 per second
// - Start conversion each period, idle between
// - Shutdown waits for running conversion to finish
// - Registers stay accessible during shutdown
// - Clearing shutdown starts conversion, resumes schedule
// - Resolution field picks 8, 9, 10, 12 bits
// - Conversion time doubles per resolution bit
// - Fault queue needs 1, 2, 4, 6 faults
// - Clearing below hysteresis ignores fault queue
// - Bit 15 is read-only over-temperature flag
// - Comparator mode: set above, clear below/shutdown
// - Interrupt mode: flag held until any read
// - Interrupt mode alternates rising and falling events
// - Shutdown entry clears flag in interrupt mode
// - Reset gives normal, 0.25/s, timeout on, 10-bit
// - Bit 3 enables CRC-8 check byte
// - Sender of last data byte sends check byte
// - Overrun conversion keeps last valid result
// - Hysteresis above threshold treated as threshold
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_ctrl
    import temp_sensor_pkg::*;
#(
    parameter int unsigned SLOT_CYCLES   = SLOT_CYCLES_DEF,
    parameter int unsigned CONV10_CYCLES = CONV10_CYCLES_DEF
) (
    input  wire logic               clk,
    input  wire logic               reset_n,
    input  wire reg_req_t           regReq,
    input  wire logic signed [15:0] sensorTemp,
    input  wire pec_in_t            pecIn,
    output var  logic [15:0]        regRdData,
    output var  logic               convBusy,
    output var  logic               overTempFlag,
    output var  logic               pecEnable,
    output var  logic               timeoutDisable,
    output var  logic [7:0]         pecCrc
);

    config_t           cfg_q;
    logic [15:0]       hyst_q;
    logic [15:0]       ot_q;
    logic [15:0]       temp_q;
    conv_state_t       state_q;
    conv_state_t       state_d;
    logic [31:0]       slotCnt_q;
    logic [4:0]        slotNum_q;
    logic [31:0]       convCnt_q;
    logic [2:0]        faultCnt_q;
    logic              otFlag_q;
    logic              armRise_q;
    logic              fmtApplied_q;
    logic [15:0]       regRdData_q;
    logic [7:0]        pecCrc_q;
    logic              convBusy_q;

    // Register port decode; every register works in any state
    wire wrCfg   = regReq.wr && (regReq.addr == PTR_CONFIG);
    wire wrHyst  = regReq.wr && (regReq.addr == PTR_HYST);
    wire wrOt    = regReq.wr && (regReq.addr == PTR_OT);
    wire config_t wrCfgData = config_t'(regReq.data & CFG_WR_MASK);
    wire sdnWake = wrCfg && cfg_q.shutdown && !wrCfgData.shutdown;
    wire stayDown  = cfg_q.shutdown && !sdnWake; // Wake beats pending entry
    wire resChange = wrCfg && (wrCfgData.resolution != cfg_q.resolution);

    // Timebase: fixed slots of the fastest period, counted per rate
    wire slotTick = (slotCnt_q == 32'(SLOT_CYCLES - 1));
    logic [4:0] slotsPerConv;
    always_comb begin
        case (cfg_q.rate)
            2'h0:    slotsPerConv = 5'h1f; // 4 s
            2'h1:    slotsPerConv = 5'h07; // 1 s
            2'h2:    slotsPerConv = 5'h01; // 0.25 s
            default: slotsPerConv = 5'h00; // 0.125 s
        endcase
    end
    wire rateStart = slotTick && (slotNum_q >= slotsPerConv);

    // Conversion length scales with resolution
    logic [31:0] convLen;
    logic [3:0]  dropBits;
    always_comb begin
        case (cfg_q.resolution)
            2'h0: begin
                convLen  = 32'(CONV10_CYCLES >> 2);
                dropBits = 4'h8;
            end
            2'h1: begin
                convLen  = 32'(CONV10_CYCLES >> 1);
                dropBits = 4'h7;
            end
            2'h2: begin
                convLen  = 32'(CONV10_CYCLES);
                dropBits = 4'h6;
            end
            default: begin
                convLen  = 32'(CONV10_CYCLES << 2);
                dropBits = 4'h4;
            end
        endcase
    end
    wire converting = (state_q == ST_CONVERT);
    wire convDone   = converting && (convCnt_q == convLen - 32'h1);
    // A new period arriving mid-conversion aborts it; temp_q is untouched
    wire convAbort  = converting && !convDone && rateStart
                      && !cfg_q.shutdown;

    // Scheduler state machine
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (stayDown) begin
                    state_d = ST_SHUTDOWN;
                end else if (rateStart || sdnWake) begin
                    state_d = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (convDone) begin
                    // Shutdown pending during a conversion is entered here, once it ends
                    state_d = stayDown ? ST_SHUTDOWN : ST_IDLE;
                end
            end
            ST_SHUTDOWN: begin
                if (sdnWake) begin
                    state_d = ST_CONVERT;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end
    wire enterShdn = (state_d == ST_SHUTDOWN) && (state_q != ST_SHUTDOWN);

    // Result formatting; saturate rather than wrap in normal format
    logic signed [15:0] normVal;
    always_comb begin
        if (sensorTemp > NORM_MAX) begin
            normVal = 16'sh7fff;
        end else if (sensorTemp < NORM_MIN) begin
            normVal = 16'sh8000;
        end else begin
            normVal = {sensorTemp[11:0], 4'h0};
        end
    end
    wire [15:0] extVal  = {sensorTemp[12:0], 3'h0};
    wire [3:0]  dropAll = dropBits - {3'h0, cfg_q.extFormat};
    wire [15:0] resMask = 16'hffff << dropAll;
    // Format taken from the bit as it stands at completion
    wire [15:0] newTemp = (cfg_q.extFormat ? extVal : normVal) & resMask;

    // Threshold compare; thresholds used raw in current format
    wire signed [15:0] otS   = ot_q;
    wire signed [15:0] hystS = hyst_q;
    wire signed [15:0] hystEff = (hystS > otS) ? otS : hystS;
    wire signed [15:0] newS  = newTemp;
    wire over  = newS > otS;
    wire under = newS < hystEff;

    // Fault queue depth
    logic [2:0] faultNeed;
    always_comb begin
        case (cfg_q.faultQueue)
            2'h0:    faultNeed = 3'h1;
            2'h1:    faultNeed = 3'h2;
            2'h2:    faultNeed = 3'h4;
            default: faultNeed = 3'h6;
        endcase
    end
    wire [2:0] faultNext = (faultCnt_q < FAULT_SAT) ? faultCnt_q + 3'h1
                                                    : FAULT_SAT;
    wire qualified = over && (faultNext >= faultNeed);
    // Falling event bypasses the queue
    wire setEvt = convDone && cfg_q.intMode
                  && (armRise_q ? qualified : under);
    wire rdClear = regReq.rd && cfg_q.intMode && otFlag_q && !setEvt;

    // Register read mux; bit 15 reflects the live flag
    logic [15:0] rdMux;
    always_comb begin
        case (regReq.addr)
            PTR_TEMP:   rdMux = temp_q;
            PTR_CONFIG: rdMux = {otFlag_q, 15'(cfg_q)};
            PTR_HYST:   rdMux = hyst_q;
            default:    rdMux = ot_q;
        endcase
    end

    // CRC-8, one byte per cycle, MSB first
    function automatic logic [7:0] crcByte(input logic [7:0] crc,
                                           input logic [7:0] din);
        logic [7:0] c;
        c = crc ^ din;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction

    // Configuration and threshold registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cfg_q  <= config_t'(CFG_RESET);
            hyst_q <= HYST_RESET;
            ot_q   <= OT_RESET;
        end else begin
            if (wrCfg) cfg_q <= wrCfgData;
            if (wrHyst) hyst_q <= regReq.data;
            if (wrOt) ot_q <= regReq.data;
        end
    end

    // Scheduler registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q   <= ST_CONVERT; // First result right after power-up
            slotCnt_q <= 32'h0;
            slotNum_q <= 5'h0;
            convCnt_q <= 32'h0;
        end else begin
            state_q <= state_d;
            // Schedule restarts from the wake-up conversion
            if (state_q == ST_SHUTDOWN || sdnWake || slotTick) begin
                slotCnt_q <= 32'h0;
            end else begin
                slotCnt_q <= slotCnt_q + 32'h1;
            end
            if (state_q == ST_SHUTDOWN || sdnWake || rateStart) begin
                slotNum_q <= 5'h0;
            end else if (slotTick) begin
                slotNum_q <= slotNum_q + 5'h1;
            end
            if (!converting || convDone || convAbort || resChange) begin
                convCnt_q <= 32'h0;
            end else begin
                convCnt_q <= convCnt_q + 32'h1;
            end
        end
    end

    // Result register and applied format
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            temp_q       <= TEMP_RESET;
            fmtApplied_q <= 1'b0;
        end else if (convDone) begin
            temp_q       <= newTemp;
            fmtApplied_q <= cfg_q.extFormat;
        end
    end

    // Fault count tracks consecutive over-threshold results
    always_ff @(posedge clk) begin
        if (!reset_n || enterShdn) begin
            faultCnt_q <= 3'h0;
        end else if (convDone) begin
            faultCnt_q <= over ? faultNext : 3'h0;
        end
    end

    // Over-temperature flag; a new event beats a read in the same cycle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            otFlag_q  <= 1'b0;
            armRise_q <= 1'b1;
        end else if (enterShdn) begin
            otFlag_q  <= 1'b0;
            armRise_q <= 1'b1;
        end else if (cfg_q.intMode) begin
            if (setEvt) begin
                otFlag_q <= 1'b1;
            end else if (rdClear) begin
                otFlag_q  <= 1'b0;
                armRise_q <= ~armRise_q;
            end
        end else if (convDone) begin
            if (qualified) begin
                otFlag_q <= 1'b1;
            end else if (under) begin
                otFlag_q <= 1'b0;
            end
        end
    end

    // Read data, busy, and check byte engine
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            regRdData_q <= 16'h0000;
            convBusy_q  <= 1'b0;
            pecCrc_q    <= 8'h00;
        end else begin
            if (regReq.rd) regRdData_q <= rdMux;
            convBusy_q <= (state_d == ST_CONVERT);
            if (pecIn.clr) begin
                pecCrc_q <= 8'h00;
            end else if (pecIn.valid && cfg_q.pecEnable) begin
                pecCrc_q <= crcByte(pecCrc_q, pecIn.data);
            end
        end
    end

    // All outputs straight from flip-flops
    assign regRdData      = regRdData_q;
    assign convBusy       = convBusy_q;
    assign overTempFlag   = otFlag_q;
    assign pecEnable      = cfg_q.pecEnable;
    assign timeoutDisable = cfg_q.timeoutDis;
    assign pecCrc         = pecCrc_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_cfg_reset_value: assert property (
        $rose(reset_n) |-> cfg_q == config_t'(CFG_RESET))
        else $error("Config not at reset value");
    a_shdn_waits_done: assert property (
        converting && !convDone |=> state_q != ST_SHUTDOWN)
        else $error("Shutdown entered mid-conversion");
    a_shdn_clears_flag: assert property (
        enterShdn |=> !otFlag_q && state_q == ST_SHUTDOWN)
        else $error("Shutdown entry left flag set");
    a_wake_converts: assert property (
        state_q == ST_SHUTDOWN && sdnWake |=> converting && convCnt_q == 0)
        else $error("Wake did not start a conversion");
    a_read_clears_int: assert property (
        rdClear && !enterShdn |=> !otFlag_q && armRise_q != $past(armRise_q))
        else $error("Read did not clear interrupt flag");
    a_hyst_clipped: assert property (
        convDone && otFlag_q && !cfg_q.intMode && !enterShdn
        && newS >= otS |=> otFlag_q) else $error("Hysteresis not clipped");
    a_fmt_on_done: assert property (
        !convDone |=> $stable(fmtApplied_q) && $stable(temp_q))
        else $error("Result changed without conversion");
    a_fault_queue: assert property (
        !cfg_q.intMode && convDone && over && faultNext < faultNeed
        && !otFlag_q |=> !otFlag_q)
        else $error("Flag set before fault count reached");
    a_conv_bounded: assert property (
        converting |-> convCnt_q < convLen)
        else $error("Conversion ran past its length");
    a_pec_clear: assert property (
        pecIn.clr |=> pecCrc_q == 8'h00)
        else $error("Check byte not cleared");

    c_conv_done:   cover property (convDone);
    c_int_cycle:   cover property (setEvt ##[1:1000] rdClear);
    c_shdn_wake:   cover property (enterShdn ##[1:1000] sdnWake);
    c_overrun:     cover property (convAbort);

endmodule

`default_nettype wire

// ===== core/temp_sensor_pkg.sv
// Shared constants and types for the temperature sensor control block.
// Assumes a single 100 MHz clock and a register port already decoded
// from the serial bus framing logic.
package temp_sensor_pkg;

    // Clock and nominal times
    localparam int unsigned CLK_FREQ_HZ       = 100_000_000;
    localparam int unsigned CONV_TIME_10B_MS  = 35;   // 10-bit conversion
    localparam int unsigned SLOT_TIME_MS      = 125;  // Fastest rate period
    localparam int unsigned CONV10_CYCLES_DEF =
        CONV_TIME_10B_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned SLOT_CYCLES_DEF   =
        SLOT_TIME_MS * (CLK_FREQ_HZ / 1000);

    // Register pointers
    localparam logic [1:0] PTR_TEMP   = 2'h0;
    localparam logic [1:0] PTR_CONFIG = 2'h1;
    localparam logic [1:0] PTR_HYST   = 2'h2;
    localparam logic [1:0] PTR_OT     = 2'h3;

    // Reset values and writable bits
    localparam logic [15:0] TEMP_RESET   = 16'h0000;
    localparam logic [15:0] CFG_RESET    = 16'h0040;
    localparam logic [15:0] HYST_RESET   = 16'h4b00;
    localparam logic [15:0] OT_RESET     = 16'h5000;
    localparam logic [15:0] CFG_WR_MASK  = 16'h1bfe;

    // Limits of the normal format, in sixteenths of a degree
    localparam logic signed [15:0] NORM_MAX = 16'sh07ff;
    localparam logic signed [15:0] NORM_MIN = 16'shf800;
    localparam logic [2:0]          FAULT_SAT = 3'h6;

    // Configuration register layout, bit 15 down to bit 0
    typedef struct packed {
        logic       otFlag;
        logic [1:0] rsvdHigh;
        logic [1:0] faultQueue;
        logic       rsvdMid;
        logic       intMode;
        logic       shutdown;
        logic       extFormat;
        logic [1:0] resolution;
        logic       timeoutDis;
        logic       pecEnable;
        logic [1:0] rate;
        logic       oneShot;
    } config_t;

    // Register access from the serial interface
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [1:0]  addr;
        logic [15:0] data;
    } reg_req_t;

    // Packet check byte stream
    typedef struct packed {
        logic       clr;
        logic       valid;
        logic [7:0] data;
    } pec_in_t;

    typedef enum logic [1:0] { ST_IDLE, ST_CONVERT, ST_SHUTDOWN } conv_state_t;

endpackage

// ===== verif/host_model.sv
// Host model of the serial bus master, seen at the decoded word port.
// Assumes framing logic outside turns bus traffic into word accesses.
`timescale 1ns/1ps
`default_nettype none
module host_model
    import temp_sensor_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [15:0] regRdData,
    output var  reg_req_t    regReq,
    output var  pec_in_t     pecIn
);
    // Idle at time zero so the block never sees floating requests
    initial begin
        regReq = '0;
        pecIn  = '0;
    end

    // Thresholds go out exactly as the caller formats them
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk);
        regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    // Read data lands on the edge that takes the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        regReq.rd   <= 1'b1;
        regReq.addr <= a;
        @(posedge clk);
        regReq.rd   <= 1'b0;
        regReq.addr <= ~a;
        #1 d = regRdData;
    endtask

    // Host streams the message bytes it sent itself
    task automatic pec_send(input logic c, input logic [7:0] b);
        @(posedge clk);
        pecIn <= '{clr: c, valid: ~c, data: b};
        @(posedge clk);
        pecIn <= '{clr: 1'b0, valid: 1'b0, data: ~b};
    endtask
endmodule
`default_nettype wire

// ===== verif/tb_temp_sensor_ctrl.sv
// Self-checking bench for the sensor control block.
// Assumes short timebase parameters; the host model drives the ports.
`timescale 1ns/1ps
`default_nettype none
module tb_temp_sensor_ctrl
    import temp_sensor_pkg::*;
;
    localparam int SLOT = 400;
    localparam int C10  = 120;
    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic signed [15:0] sensorTemp = 16'sh0000;
    reg_req_t           regReq;
    pec_in_t            pecIn;
    logic [15:0]        regRdData, rd;
    logic               convBusy, overTempFlag, pecEnable, timeoutDisable;
    logic [7:0]         pecCrc, c;
    int                 num_errors = 0;
    int                 n_checks = 0;
    int                 n, m, k;

    // Clock and design wiring
    always #5 clk = ~clk;
    temp_sensor_ctrl #(.SLOT_CYCLES(SLOT), .CONV10_CYCLES(C10))
        temp_sensor_ctrl_i (.clk(clk), .reset_n(reset_n), .regReq(regReq),
        .sensorTemp(sensorTemp), .pecIn(pecIn), .regRdData(regRdData),
        .convBusy(convBusy), .overTempFlag(overTempFlag),
        .pecEnable(pecEnable), .timeoutDisable(timeoutDisable),
        .pecCrc(pecCrc));
    host_model host_model_i (.clk(clk), .regRdData(regRdData),
        .regReq(regReq), .pecIn(pecIn));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Bounded wait for a busy level; cnt counts the cycles spent
    task automatic wait_busy(input logic v, output int cnt);
        cnt = 0;
        #1;
        while (convBusy !== v) begin
            @(posedge clk);
            #1 cnt++;
            if (cnt > 20000) begin
                num_errors++;
                close_out();
            end
        end
    endtask

    task automatic conv();
        wait_busy(1'b1, n);
        wait_busy(1'b0, n);
    endtask

    task automatic rdc(input logic [1:0] a, input logic [15:0] e);
        host_model_i.rd_reg(a, rd);
        chk(rd, e);
    endtask

    // Fields: fault queue, {intMode, shutdown, extFormat, pec}, res, rate
    task automatic wcfg(input logic [1:0] fq, input logic [3:0] f,
                        input logic [1:0] rs, input logic [1:0] rt);
        host_model_i.wr_reg(PTR_CONFIG, {3'h0, fq, 1'b0, f[3:1], rs,
                                         1'b0, f[0], rt, 1'b0});
    endtask

    task automatic st(input logic [15:0] v);
        @(posedge clk);
        sensorTemp <= v;
    endtask

    task automatic t_regs();
        rdc(PTR_CONFIG, 16'h0040);
        rdc(PTR_HYST, 16'h4b00);
        rdc(PTR_OT, 16'h5000);
        host_model_i.wr_reg(PTR_TEMP, 16'hffff);
        host_model_i.wr_reg(PTR_CONFIG, 16'hffff);
        rdc(PTR_TEMP, 16'h0000);
        rdc(PTR_CONFIG, 16'h1bfe);
        chk({14'h0, pecEnable, timeoutDisable}, 16'h0003);
        wcfg(2'h0, 4'h0, 2'h0, 2'h3);
        $display("regs done");
    endtask

    // Start spacing per rate, after one conversion to resync
    task automatic t_rate();
        int sl [4] = '{32, 8, 2, 1};
        for (int rt = 3; rt >= 0; rt--) begin
            wcfg(2'h0, 4'h0, 2'h0, rt[1:0]);
            conv();
            wait_busy(1'b1, n);
            wait_busy(1'b0, m);
            wait_busy(1'b1, k);
            chk(16'(m + k), 16'(sl[rt] * SLOT));
            chk(16'(m), 16'(C10 / 4));
        end
        $display("rate done");
    endtask

    task automatic t_res();
        int drop;
        st(16'h0123);
        for (int i = 0; i < 8; i++) begin
            wcfg(2'h0, {2'h0, i[2], 1'b0}, i[1:0], 2'h2);
            conv();
            conv();
            chk(16'(n), 16'(i % 4 == 3 ? C10 * 4 : C10 >> (2 - i % 4)));
            drop = (i % 4 == 3 ? 4 : 8 - i % 4) - i / 4;
            rdc(PTR_TEMP, (i[2] ? 16'h0918 : 16'h1230)
                & (16'hffff << drop));
        end
        $display("resolution done");
    endtask

    task automatic t_fmt();
        wcfg(2'h0, 4'h0, 2'h2, 2'h3);
        st(16'sd2400);
        conv();
        rdc(PTR_TEMP, 16'h7fc0);
        wcfg(2'h0, 4'h2, 2'h2, 2'h3);
        rdc(PTR_TEMP, 16'h7fc0);
        conv();
        rdc(PTR_TEMP, 16'h4b00);
        rdc(PTR_OT, 16'h5000);
        st(-16'sd640);
        conv();
        rdc(PTR_TEMP, 16'hec00);
        $display("format done");
    endtask

    task automatic t_cmp();
        logic [15:0] need [4] = '{16'h1, 16'h2, 16'h4, 16'h6};
        host_model_i.wr_reg(PTR_OT, 16'h1900);
        host_model_i.wr_reg(PTR_HYST, 16'h1400);
        for (int q = 0; q < 4; q++) begin
            wcfg(q[1:0], 4'h0, 2'h0, 2'h3);
            st(16'h0100);
            conv();
            conv();
            st(16'h0200);
            k = 0;
            while (k < 8 && overTempFlag !== 1'b1) begin
                conv();
                k++;
            end
            chk(16'(k), need[q]);
        end
        // Hysteresis stored above threshold acts as the threshold
        host_model_i.wr_reg(PTR_HYST, 16'h7f00);
        st(16'h0190);
        conv();
        chk({15'h0, overTempFlag}, 16'h0001);
        rdc(PTR_CONFIG, 16'h9806);
        st(16'h0100);
        conv();
        chk({15'h0, overTempFlag}, 16'h0000);
        $display("comparator done");
    endtask

    task automatic t_int();
        host_model_i.wr_reg(PTR_HYST, 16'h1400);
        wcfg(2'h0, 4'hc, 2'h0, 2'h3);
        wait_busy(1'b0, n);
        wcfg(2'h0, 4'h8, 2'h0, 2'h3);
        st(16'h0200);
        conv();
        conv();
        chk({15'h0, overTempFlag}, 16'h0001);
        rdc(PTR_HYST, 16'h1400);
        chk({15'h0, overTempFlag}, 16'h0000);
        conv();
        chk({15'h0, overTempFlag}, 16'h0000);
        st(16'h0100);
        conv();
        chk({15'h0, overTempFlag}, 16'h0001);
        rdc(PTR_TEMP, 16'h1000);
        st(16'h0200);
        conv();
        chk({15'h0, overTempFlag}, 16'h0001);
        wcfg(2'h0, 4'hc, 2'h0, 2'h3);
        wait_busy(1'b0, n);
        repeat (2) @(posedge clk);
        #1 chk({15'h0, overTempFlag}, 16'h0000);
        $display("interrupt done");
    endtask

    task automatic t_sd();
        wcfg(2'h0, 4'h0, 2'h0, 2'h3);
        conv();
        wait_busy(1'b1, n);
        wcfg(2'h0, 4'h4, 2'h0, 2'h3);
        #1 chk({14'h0, convBusy, overTempFlag}, 16'h0003);
        wait_busy(1'b0, n);
        repeat (2) @(posedge clk);
        #1 chk({15'h0, overTempFlag}, 16'h0000);
        k = 0;
        repeat (1000) begin
            @(posedge clk);
            #1 if (convBusy !== 1'b0) k++;
        end
        chk(16'(k), 16'h0000);
        host_model_i.wr_reg(PTR_HYST, 16'h1234);
        rdc(PTR_HYST, 16'h1234);
        wcfg(2'h0, 4'h0, 2'h0, 2'h3);
        wait_busy(1'b1, n);
        chk({15'h0, n <= 2}, 16'h0001);
        $display("shutdown done");
    endtask

    // Slow resolution at the fast rate: every conversion is cut short
    task automatic t_ovr();
        st(16'h0100);
        conv();
        wcfg(2'h0, 4'h0, 2'h3, 2'h3);
        st(16'h0200);
        repeat (1300) @(posedge clk);
        rdc(PTR_TEMP, 16'h1000);
        $display("overrun done");
    endtask

    task automatic t_pec();
        logic [7:0] msg [3] = '{8'h90, 8'h01, 8'h23};
        wcfg(2'h0, 4'h1, 2'h0, 2'h3);
        host_model_i.pec_send(1'b1, 8'h00);
        #1 chk({8'h0, pecCrc}, 16'h0000);
        c = 8'h00;
        foreach (msg[j]) begin
            host_model_i.pec_send(1'b0, msg[j]);
            c = c ^ msg[j];
            repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
            #1 chk({8'h0, pecCrc}, {8'h0, c});
        end
        wcfg(2'h0, 4'h0, 2'h0, 2'h3);
        host_model_i.pec_send(1'b0, 8'h55);
        #1 chk({7'h0, pecEnable, pecCrc}, {8'h0, c});
        $display("check byte done");
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_rate();
        t_res();
        t_fmt();
        t_cmp();
        t_int();
        t_sd();
        t_ovr();
        t_pec();
        close_out();
    end
endmodule
`default_nettype wire
